/* common/ldc_pkg.sv */
// constants shared by the led dimming control core
// Functional notes
// - enable pin drives led output and aux regulator
// - floating foldback pin enables foldback, low disables
// - supply loss clears all dynamic settings
// - power-up copies stored settings into dynamic registers
// - transfer register write reloads stored settings
// - serial writes update settings immediately, except in load cycles
// - three edges of 80Hz-2kHz select external pwm
// - otherwise gate on while level exceeds ramp
// - ramp peak comes from ramp peak register
// - duty is (level minus 0.21V) over peak, clamped
// - shared pins are bus only in programming mode
// - dedicated bus pins serve programming only
// - each button press toggles full duty latch
// - full duty never beats pwm or foldback
// - 3-bit peak code, 1.55V to 2.88V
package ldc_pkg;

	// clock and timing
	localparam int unsigned LDC_CLK_HZ      = 10_000_000;            // core clock rate
	localparam int unsigned LDC_RAMP_HZ     = 200;                   // internal ramp rate
	localparam int unsigned LDC_RAMP_CYC    = LDC_CLK_HZ / LDC_RAMP_HZ;
	localparam int unsigned LDC_PWM_MIN_HZ  = 80;                    // slowest external pwm
	localparam int unsigned LDC_PWM_MAX_HZ  = 2000;                  // fastest external pwm
	localparam int unsigned LDC_PER_MAX_CYC = LDC_CLK_HZ / LDC_PWM_MIN_HZ;
	localparam int unsigned LDC_PER_MIN_CYC = (LDC_CLK_HZ + LDC_PWM_MAX_HZ - 1) / LDC_PWM_MAX_HZ;
	localparam int unsigned LDC_TMO_RAMPS   = 4;                     // ramp periods without pulses
	localparam int unsigned LDC_TMO_CYC     = LDC_TMO_RAMPS * LDC_RAMP_CYC;
	localparam int unsigned LDC_DEB_MS      = 20;                    // button settle time
	localparam int unsigned LDC_DEB_CYC     = (LDC_CLK_HZ / 1000) * LDC_DEB_MS;
	localparam int unsigned LDC_TW          = 18;                    // timer width
	localparam int unsigned LDC_EDGES       = 3;                     // edges to lock pwm mode

	// brightness levels in millivolts
	localparam int unsigned LDC_LW          = 12;                    // level width
	localparam logic [11:0] LDC_DIM_OFS_MV  = 12'h0D2;               // 0.21V offset
	localparam logic [11:0] LDC_PEAK_MV [8] = '{12'h60E, 12'h6CC, 12'h78A, 12'h848,
	                                            12'h910, 12'h9CE, 12'hA8C, 12'hB40};

	// settings register addresses and widths
	localparam logic [7:0] LDC_A_BIN        = 8'h00;                 // binning adjustment
	localparam logic [7:0] LDC_A_PEAK       = 8'h01;                 // ramp peak
	localparam logic [7:0] LDC_A_CFT        = 8'h02;                 // foldback threshold
	localparam logic [7:0] LDC_A_KNEE       = 8'h03;                 // thermal knee
	localparam logic [7:0] LDC_A_SLOPE      = 8'h04;                 // thermal slope
	localparam logic [7:0] LDC_A_CLAMP      = 8'h05;                 // thermal clamp
	localparam logic [7:0] LDC_A_XFER       = 8'h06;                 // storage transfer
	localparam logic [3:0] LDC_RST4         = 4'h0;                  // cleared value, 4 bits
	localparam logic [2:0] LDC_RST3         = 3'h0;                  // cleared value, 3 bits
	localparam logic [1:0] LDC_RST2         = 2'h0;                  // cleared value, 2 bits

	// settings load sequencer
	typedef enum logic [1:0] {
		LDC_ST_BOOT = 2'b00,                                         // power-up copy
		LDC_ST_RUN  = 2'b01,                                         // normal operation
		LDC_ST_XFER = 2'b10                                          // commanded reload
	} ldc_state_type;

endpackage

/* logic/ldc_debounce.sv */
// pushbutton synchroniser and debouncer
`timescale 1ns/10ps
module ldc_debounce
	import ldc_pkg::*;
#(
	parameter int unsigned DEB_CYC = LDC_DEB_CYC
) (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic btn_in,
	output logic      press
);
	logic [1:0]        sync_q;   // two-stage synchroniser
	logic              stable_q; // accepted button level
	logic [LDC_TW-1:0] cnt_q;    // settle counter
	logic              differ;   // raw level disagrees with accepted one

	assign differ = sync_q[1] ^ stable_q;

	// synchronise pin
	always_ff @(posedge clk) begin
		if (rst) begin
			sync_q <= 2'h0;
		end else begin
			sync_q <= {sync_q[0], btn_in};
		end
	end

	// accept a level only after it holds for the whole settle time
	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_q    <= '0;
			stable_q <= 1'b0;
			press    <= 1'b0;
		end else if (!differ) begin
			cnt_q <= '0;
			press <= 1'b0;
		end else if (cnt_q >= LDC_TW'(DEB_CYC - 1)) begin
			cnt_q    <= '0;
			stable_q <= sync_q[1];
			press    <= sync_q[1];
		end else begin
			cnt_q <= cnt_q + 1'b1;
			press <= 1'b0;
		end
	end
endmodule

/* logic/ldc_top.sv */
// led dimming control core: settings, ramp dimming, pwm detect, button override
`timescale 1ns/10ps
module ldc_top
	import ldc_pkg::*;
#(
	parameter int unsigned RAMP_CYC    = LDC_RAMP_CYC,
	parameter int unsigned PER_MIN_CYC = LDC_PER_MIN_CYC,
	parameter int unsigned PER_MAX_CYC = LDC_PER_MAX_CYC,
	parameter int unsigned TMO_CYC     = LDC_TMO_CYC,
	parameter int unsigned DEB_CYC     = LDC_DEB_CYC,
	parameter bit          SHARED_PINS = 1'b1
) (
	input  wire logic              CORE_CLK,
	input  wire logic              RST,
	input  wire logic              ENABLE_PIN,
	input  wire logic              FOLDBACK_DIM_ENABLE_PIN,
	input  wire logic              BRIGHTNESS_CONTROL_INPUT,
	input  wire logic              PUSHBUTTON_INPUT,
	input  wire logic              PROG_MODE_PIN,
	input  wire logic              FOLDBACK_ACTIVE,
	input  wire logic              FOLDBACK_GATE,
	input  wire logic [LDC_LW-1:0] BRIGHTNESS_INPUT_LEVEL,
	input  wire logic              REG_WR_STB,
	input  wire logic [7:0]        REG_WR_ADDR,
	input  wire logic [7:0]        REG_WR_DATA,
	input  wire logic [3:0]        NVM_BINNING,
	input  wire logic [2:0]        NVM_RAMP_PEAK,
	input  wire logic [3:0]        NVM_CFT,
	input  wire logic [3:0]        NVM_KNEE,
	input  wire logic [1:0]        NVM_SLOPE,
	input  wire logic [2:0]        NVM_CLAMP,
	output logic                   LED_OUTPUT_EN,
	output logic                   AUX_REGULATOR_OUTPUT_EN,
	output logic                   FOLDBACK_DIM_EN,
	output logic                   LED_GATE,
	output logic                   PWM_MODE,
	output logic                   FULL_DUTY,
	output logic                   BUS_PINS_SEL,
	output logic                   THERMAL_PINS_SEL,
	output logic                   SETTINGS_VALID,
	output logic [3:0]             BINNING,
	output logic [2:0]             RAMP_PEAK_LEVEL,
	output logic [3:0]             CFT,
	output logic [3:0]             KNEE,
	output logic [1:0]             SLOPE,
	output logic [2:0]             CLAMP
);
	// pin synchronisers, first stage read only by second
	logic [4:0]          pin_s1_q;      // first stage
	logic [4:0]          pin_s2_q;      // second stage
	logic                en_s;          // enable pin
	logic                cfd_s;         // foldback enable pin
	logic                dim_s;         // brightness pulse input
	logic                prog_s;        // programming mode pin
	logic                fbg_s;         // foldback gate from analog loop

	// settings sequencer
	ldc_state_type       state_q;       // sequencer state
	ldc_state_type       state_d;       // next state
	logic                load_now;      // copy stored settings this cycle
	logic                wr_ok;         // serial write accepted

	// ramp and comparison
	logic [LDC_TW-1:0]   phase_q;       // ramp position in cycles
	logic                phase_end;     // last cycle of ramp period
	logic [11:0]         peak_mv;       // selected peak in millivolts
	logic [11:0]         above_mv;      // level above the 0.21V offset
	logic [29:0]         lhs;           // scaled level
	logic [29:0]         rhs;           // scaled ramp
	logic                dc_on;         // dc comparison result

	// pulse detector
	logic                dim_prev_q;    // previous brightness sample
	logic                dim_rise;      // rising edge seen
	logic [LDC_TW-1:0]   per_q;         // cycles since last rising edge
	logic [1:0]          edge_cnt_q;    // qualifying edges counted
	logic                per_ok;        // period within 80Hz..2kHz
	logic                timeout;       // pulses stopped
	logic                pwm_mode_q;    // external pwm selected

	// button override
	logic                press;         // debounced press pulse
	logic                full_q;        // full duty latch
	logic                fb_on;         // foldback dimming in force
	logic                gate_d;        // next led gate

	// pin map onto synchroniser vector
	assign en_s   = pin_s2_q[0];
	assign cfd_s  = pin_s2_q[1];
	assign dim_s  = pin_s2_q[2];
	assign prog_s = pin_s2_q[3];
	assign fbg_s  = pin_s2_q[4];

	// two-stage synchroniser for all pins except the pushbutton and FOLDBACK_ACTIVE
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			pin_s1_q <= 5'h00;
			pin_s2_q <= 5'h00;
		end else begin
			pin_s1_q <= {FOLDBACK_GATE, PROG_MODE_PIN, BRIGHTNESS_CONTROL_INPUT,
			             FOLDBACK_DIM_ENABLE_PIN, ENABLE_PIN};
			pin_s2_q <= pin_s1_q;
		end
	end

	// sequencer decode
	assign load_now = (state_q != LDC_ST_RUN);
	assign wr_ok    = REG_WR_STB && (state_q == LDC_ST_RUN);

	// sequencer next state
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			LDC_ST_BOOT: begin
				state_d = LDC_ST_RUN;
			end
			LDC_ST_RUN: begin
				if (wr_ok && REG_WR_ADDR == LDC_A_XFER) begin
					state_d = LDC_ST_XFER;
				end
			end
			LDC_ST_XFER: begin
				state_d = LDC_ST_RUN;
			end
			default: begin
				state_d = LDC_ST_BOOT;                                            // illegal code recovers
			end
		endcase
	end

	// sequencer state register
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			state_q <= LDC_ST_BOOT;
		end else begin
			state_q <= state_d;
		end
	end

	// dynamic settings: cleared by reset, loaded from storage, written serially
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			BINNING         <= LDC_RST4;
			RAMP_PEAK_LEVEL <= LDC_RST3;
			CFT             <= LDC_RST4;
			KNEE            <= LDC_RST4;
			SLOPE           <= LDC_RST2;
			CLAMP           <= LDC_RST3;
		end else if (load_now) begin
			BINNING         <= NVM_BINNING;
			RAMP_PEAK_LEVEL <= NVM_RAMP_PEAK;
			CFT             <= NVM_CFT;
			KNEE            <= NVM_KNEE;
			SLOPE           <= NVM_SLOPE;
			CLAMP           <= NVM_CLAMP;
		end else if (wr_ok) begin
			// only the low bits of each byte are kept
			unique case (REG_WR_ADDR)
				LDC_A_BIN:   BINNING         <= REG_WR_DATA[3:0];
				LDC_A_PEAK:  RAMP_PEAK_LEVEL <= REG_WR_DATA[2:0];
				LDC_A_CFT:   CFT             <= REG_WR_DATA[3:0];
				LDC_A_KNEE:  KNEE            <= REG_WR_DATA[3:0];
				LDC_A_SLOPE: SLOPE           <= REG_WR_DATA[1:0];
				LDC_A_CLAMP: CLAMP           <= REG_WR_DATA[2:0];
				default: begin
				end
			endcase
		end
	end

	// ramp phase counter, one period of the 200Hz ramp
	assign phase_end = (phase_q >= LDC_TW'(RAMP_CYC - 1));

	always_ff @(posedge CORE_CLK) begin
		if (RST || phase_end) begin
			phase_q <= '0;
		end else begin
			phase_q <= phase_q + 1'b1;
		end
	end

	// level minus offset against ramp scaled to peak; clamps fall out naturally
	assign peak_mv  = LDC_PEAK_MV[RAMP_PEAK_LEVEL];
	assign above_mv = (BRIGHTNESS_INPUT_LEVEL > LDC_DIM_OFS_MV) ?
	                  (BRIGHTNESS_INPUT_LEVEL - LDC_DIM_OFS_MV) : 12'h000;
	assign lhs      = 30'(above_mv) * 30'(RAMP_CYC);
	assign rhs      = 30'(phase_q) * 30'(peak_mv);
	assign dc_on    = (lhs > rhs);

	// pulse detector decode
	assign dim_rise = dim_s && !dim_prev_q;
	assign per_ok   = (per_q >= LDC_TW'(PER_MIN_CYC - 1)) && (per_q <= LDC_TW'(PER_MAX_CYC - 1));
	assign timeout  = (per_q >= LDC_TW'(TMO_CYC - 1));

	// period timer between rising edges, saturating
	always_ff @(posedge CORE_CLK) begin
		if (RST || dim_rise) begin
			per_q <= '0;
		end else if (!timeout) begin
			per_q <= per_q + 1'b1;
		end
	end

	// edge qualifier and mode latch
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			dim_prev_q <= 1'b0;
			edge_cnt_q <= 2'h0;
			pwm_mode_q <= 1'b0;
		end else begin
			dim_prev_q <= dim_s;
			if (timeout) begin
				// a rise that ends a silence still counts as the first edge
				edge_cnt_q <= dim_rise ? 2'h1 : 2'h0;
				pwm_mode_q <= 1'b0;
			end else if (dim_rise) begin
				if (edge_cnt_q == 2'h0 || !per_ok) begin
					edge_cnt_q <= 2'h1;                                           // restart the count
				end else if (edge_cnt_q == 2'(LDC_EDGES - 1)) begin
					edge_cnt_q <= 2'(LDC_EDGES - 1);
					pwm_mode_q <= 1'b1;
				end else begin
					edge_cnt_q <= edge_cnt_q + 1'b1;
				end
			end
		end
	end

	// debounced pushbutton
	ldc_debounce #(
		.DEB_CYC (DEB_CYC)
	) u_btn (
		.clk    (CORE_CLK),
		.rst    (RST),
		.btn_in (PUSHBUTTON_INPUT),
		.press  (press)
	);

	// full duty latch toggles per press
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			full_q <= 1'b0;
		end else if (press) begin
			full_q <= !full_q;
		end
	end

	// gate priority: disabled, loading, pwm, foldback, override, dc ramp
	assign fb_on  = cfd_s && FOLDBACK_ACTIVE;
	assign gate_d = (!en_s || load_now) ? 1'b0 :
	                pwm_mode_q          ? dim_s :
	                fb_on               ? (fbg_s && (full_q || dc_on)) :
	                full_q              ? 1'b1 :
	                dc_on;

	// registered outputs
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			LED_OUTPUT_EN           <= 1'b0;
			AUX_REGULATOR_OUTPUT_EN <= 1'b0;
			FOLDBACK_DIM_EN         <= 1'b0;
			LED_GATE                <= 1'b0;
			PWM_MODE                <= 1'b0;
			FULL_DUTY               <= 1'b0;
			BUS_PINS_SEL            <= 1'b0;
			THERMAL_PINS_SEL        <= 1'b0;
			SETTINGS_VALID          <= 1'b0;
		end else begin
			LED_OUTPUT_EN           <= en_s;
			AUX_REGULATOR_OUTPUT_EN <= en_s;
			FOLDBACK_DIM_EN         <= cfd_s;
			LED_GATE                <= gate_d;
			PWM_MODE                <= pwm_mode_q;
			FULL_DUTY               <= full_q;
			BUS_PINS_SEL            <= SHARED_PINS ? prog_s : 1'b1;
			THERMAL_PINS_SEL        <= SHARED_PINS ? !prog_s : 1'b0;
			SETTINGS_VALID          <= !load_now;
		end
	end
endmodule

/* verification/ldc_properties.sv */
// port checker for the dimming core, bound to the top module
`timescale 1ns/10ps
module ldc_checker
	import ldc_pkg::*;
#(
	parameter int unsigned DEB_CYC = LDC_DEB_CYC
) (
	input wire logic       CORE_CLK,
	input wire logic       RST,
	input wire logic       ENABLE_PIN,
	input wire logic       FOLDBACK_DIM_ENABLE_PIN,
	input wire logic       BRIGHTNESS_CONTROL_INPUT,
	input wire logic       PUSHBUTTON_INPUT,
	input wire logic       FOLDBACK_ACTIVE,
	input wire logic       REG_WR_STB,
	input wire logic [7:0] REG_WR_ADDR,
	input wire logic [7:0] REG_WR_DATA,
	input wire logic [3:0] NVM_BINNING,
	input wire logic [2:0] NVM_RAMP_PEAK,
	input wire logic       LED_OUTPUT_EN,
	input wire logic       AUX_REGULATOR_OUTPUT_EN,
	input wire logic       FOLDBACK_DIM_EN,
	input wire logic       LED_GATE,
	input wire logic       PWM_MODE,
	input wire logic       FULL_DUTY,
	input wire logic       SETTINGS_VALID,
	input wire logic [3:0] BINNING,
	input wire logic [2:0] RAMP_PEAK_LEVEL
);
	logic [3:0]  warm_q;  // edges since reset, saturating
	logic [31:0] run_q;   // length of latest button press
	logic        xfer_q;  // last cycle carried a transfer write
	wire         warm    = (warm_q == 4'hF);
	wire         xfer_wr = REG_WR_STB && (REG_WR_ADDR == LDC_A_XFER);

	// helper state, cleared by reset
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			warm_q <= 4'h0;
			run_q  <= 32'h0;
			xfer_q <= 1'h0;
		end else begin
			warm_q <= warm ? warm_q : warm_q + 4'h1;
			run_q  <= $rose(PUSHBUTTON_INPUT) ? 32'h1 : run_q + {31'h0, PUSHBUTTON_INPUT};
			xfer_q <= xfer_wr;
		end
	end

	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (RST);

	// accepted transfer write, then one load cycle
	sequence xfer_req_s;
		xfer_wr && SETTINGS_VALID && !xfer_q && warm;
	endsequence
	sequence reload_s;
		SETTINGS_VALID ##1 (!SETTINGS_VALID && BINNING == NVM_BINNING && RAMP_PEAK_LEVEL == NVM_RAMP_PEAK)
			##1 SETTINGS_VALID;
	endsequence

	en_follow_a: assert property (warm |-> LED_OUTPUT_EN == $past(ENABLE_PIN, 3)
		&& AUX_REGULATOR_OUTPUT_EN == LED_OUTPUT_EN) else $error("enable outputs differ from pin");
	gate_disabled_a: assert property (!LED_OUTPUT_EN && !$past(LED_OUTPUT_EN) |-> !LED_GATE)
		else $error("led gate on while disabled");
	foldback_pin_a: assert property (warm |-> FOLDBACK_DIM_EN == $past(FOLDBACK_DIM_ENABLE_PIN, 3))
		else $error("foldback enable differs from pin");
	reset_clear_a: assert property ($fell(RST) |-> BINNING == LDC_RST4 && RAMP_PEAK_LEVEL == LDC_RST3
		&& !SETTINGS_VALID && !LED_GATE) else $error("settings not cleared by reset");
	boot_copy_a: assert property ($fell(RST) |=> (BINNING == NVM_BINNING && RAMP_PEAK_LEVEL == NVM_RAMP_PEAK)
		##1 SETTINGS_VALID) else $error("stored settings not loaded at start");
	xfer_reload_a: assert property (xfer_req_s |=> reload_s)
		else $error("transfer write did not reload settings");
	write_update_a: assert property (REG_WR_STB && REG_WR_ADDR == LDC_A_PEAK && SETTINGS_VALID && !xfer_q
		|=> RAMP_PEAK_LEVEL == 3'($past(REG_WR_DATA))) else $error("peak write not applied next cycle");
	pwm_follow_a: assert property (warm && PWM_MODE && $past(PWM_MODE) && LED_OUTPUT_EN && SETTINGS_VALID
		&& $past(SETTINGS_VALID) |-> LED_GATE == $past(BRIGHTNESS_CONTROL_INPUT, 3))
		else $error("gate does not follow pwm input");
	full_duty_a: assert property (warm && FULL_DUTY && $past(FULL_DUTY) && !PWM_MODE && !$past(PWM_MODE)
		&& !$past(FOLDBACK_ACTIVE) && LED_OUTPUT_EN && $past(LED_OUTPUT_EN) && SETTINGS_VALID
		&& $past(SETTINGS_VALID) |-> LED_GATE) else $error("override latch set but gate off");
	debounce_a: assert property (warm && $changed(FULL_DUTY) |-> run_q >= DEB_CYC)
		else $error("override toggled before button settled");
endmodule

bind ldc_top ldc_checker #(.DEB_CYC(DEB_CYC)) chk (
	.CORE_CLK, .RST, .ENABLE_PIN, .FOLDBACK_DIM_ENABLE_PIN, .BRIGHTNESS_CONTROL_INPUT, .PUSHBUTTON_INPUT,
	.FOLDBACK_ACTIVE, .REG_WR_STB, .REG_WR_ADDR, .REG_WR_DATA, .NVM_BINNING, .NVM_RAMP_PEAK, .LED_OUTPUT_EN,
	.AUX_REGULATOR_OUTPUT_EN, .FOLDBACK_DIM_EN, .LED_GATE, .PWM_MODE, .FULL_DUTY, .SETTINGS_VALID,
	.BINNING, .RAMP_PEAK_LEVEL);

/* verification/ldc_host_model.sv */
// stand-in for the serial host that writes settings
`timescale 1ns/10ps
module ldc_host_model
	import ldc_pkg::*;
(
	input  wire logic       clk,
	output logic            stb,
	output logic [7:0]      addr,
	output logic [7:0]      data
);
	// bus idle at start
	initial {stb, addr, data} = 17'h0;
	// one write: strobe up for one edge, then lines scrambled
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		{stb, addr, data} <= {1'h1, a, d};
		@(posedge clk);
		{stb, addr, data} <= {1'h0, ~a, ~d};
	endtask
	// any write to the transfer register asks for a reload
	task automatic reload;
		wr(LDC_A_XFER, 8'h5A);
	endtask
endmodule

/* verification/ldc_top_tb_top.sv */
// self-checking bench for the dimming core
`timescale 1ns/10ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_fail++; \
$display("[FAIL] t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module ldc_top_tb_top
	import ldc_pkg::*;
;
	localparam int RC = 100;  // shortened ramp period
	localparam int DB = 20;   // shortened settle time
	logic        clk = 1'h0;
	logic        rst, en, fb_pin, brightness_control_input, btn, prog, fb_act, fb_gate;
	logic [11:0] lvl;         // brightness level in mV
	logic        stb;
	logic [7:0]  addr, data;
	logic [3:0]  nb, nc, nk, bin, cft, knee;
	logic [2:0]  np, nl, peak, clamp;
	logic [1:0]  ns, slope;
	logic        led_en, aux_en, fb_en, gate, pwm, full, bus_sel, th_sel, valid;
	logic        bus_ded, th_ded;   // pin routing of the dedicated-pin variant
	int          n_fail = 0;
	int          tests_run = 0;

	// 10 MHz core clock
	always #50 clk = ~clk;

	ldc_top #(.RAMP_CYC(RC), .PER_MIN_CYC(10), .PER_MAX_CYC(250), .TMO_CYC(400), .DEB_CYC(DB)) DUT (
		.CORE_CLK(clk), .RST(rst), .ENABLE_PIN(en), .FOLDBACK_DIM_ENABLE_PIN(fb_pin),
		.BRIGHTNESS_CONTROL_INPUT(brightness_control_input), .PUSHBUTTON_INPUT(btn), .PROG_MODE_PIN(prog),
		.FOLDBACK_ACTIVE(fb_act), .FOLDBACK_GATE(fb_gate), .BRIGHTNESS_INPUT_LEVEL(lvl),
		.REG_WR_STB(stb), .REG_WR_ADDR(addr), .REG_WR_DATA(data), .NVM_BINNING(nb),
		.NVM_RAMP_PEAK(np), .NVM_CFT(nc), .NVM_KNEE(nk), .NVM_SLOPE(ns), .NVM_CLAMP(nl),
		.LED_OUTPUT_EN(led_en), .AUX_REGULATOR_OUTPUT_EN(aux_en), .FOLDBACK_DIM_EN(fb_en),
		.LED_GATE(gate), .PWM_MODE(pwm), .FULL_DUTY(full), .BUS_PINS_SEL(bus_sel),
		.THERMAL_PINS_SEL(th_sel), .SETTINGS_VALID(valid), .BINNING(bin),
		.RAMP_PEAK_LEVEL(peak), .CFT(cft), .KNEE(knee), .SLOPE(slope), .CLAMP(clamp));
	// dedicated-pin variant, compared on its pin routing only
	ldc_top #(.SHARED_PINS(1'b0)) DUT_DED (
		.CORE_CLK(clk), .RST(rst), .ENABLE_PIN(en), .FOLDBACK_DIM_ENABLE_PIN(fb_pin),
		.BRIGHTNESS_CONTROL_INPUT(brightness_control_input), .PUSHBUTTON_INPUT(btn), .PROG_MODE_PIN(prog),
		.FOLDBACK_ACTIVE(fb_act), .FOLDBACK_GATE(fb_gate), .BRIGHTNESS_INPUT_LEVEL(lvl),
		.REG_WR_STB(stb), .REG_WR_ADDR(addr), .REG_WR_DATA(data), .NVM_BINNING(nb),
		.NVM_RAMP_PEAK(np), .NVM_CFT(nc), .NVM_KNEE(nk), .NVM_SLOPE(ns), .NVM_CLAMP(nl),
		.LED_OUTPUT_EN(), .AUX_REGULATOR_OUTPUT_EN(), .FOLDBACK_DIM_EN(), .LED_GATE(), .PWM_MODE(),
		.FULL_DUTY(), .BUS_PINS_SEL(bus_ded), .THERMAL_PINS_SEL(th_ded), .SETTINGS_VALID(),
		.BINNING(), .RAMP_PEAK_LEVEL(), .CFT(), .KNEE(), .SLOPE(), .CLAMP());
	ldc_host_model host (.clk(clk), .stb(stb), .addr(addr), .data(data));

	// let n edges pass, then settle
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// gate-on cycles over one ramp period
	task automatic duty(output int c);
		c = 0;
		repeat (RC) begin
			@(posedge clk);
			#1;
			c += int'(gate === 1'h1);
		end
	endtask
	// hold the button n cycles, then release
	task automatic press(input int n);
		@(posedge clk);
		btn <= 1'h1;
		repeat (n) @(posedge clk);
		btn <= 1'h0;
		cyc(DB + 10);
	endtask
	// n pulses of hi and lo cycles on the brightness input
	task automatic pulses(input int n, input int hi, input int lo);
		repeat (n) begin
			@(posedge clk);
			brightness_control_input <= 1'h1;
			repeat (hi) @(posedge clk);
			brightness_control_input <= 1'h0;
			repeat (lo - 1) @(posedge clk);
		end
	endtask
	// cleared in reset, stored copy after release
	task automatic t_boot;
		`CHK({bin, peak, valid}, 8'h00)
		@(posedge clk);
		rst <= 1'h0;
		cyc(4);
		`CHK({bin, peak, cft, knee, slope, clamp}, {nb, np, nc, nk, ns, nl})
		`CHK(valid, 1'h1)
	endtask
	// every settings register, high bits dropped, unmapped ignored
	task automatic t_regs;
		host.wr(LDC_A_BIN, 8'hF5);
		host.wr(LDC_A_PEAK, 8'hFA);
		host.wr(LDC_A_CFT, 8'h3C);
		host.wr(LDC_A_KNEE, 8'hE9);
		host.wr(LDC_A_SLOPE, 8'h7D);
		host.wr(LDC_A_CLAMP, 8'h0B);
		host.wr(8'h07, 8'hFF);
		cyc(2);
		`CHK({bin, peak, cft, knee, slope, clamp}, {4'h5, 3'h2, 4'hC, 4'h9, 2'h1, 3'h3})
	endtask
	// new stored values reach the registers on command
	task automatic t_xfer;
		@(posedge clk);
		{nb, np, nc, nk, ns, nl} <= {4'h2, 3'h0, 4'h1, 4'h4, 2'h3, 3'h1};
		host.reload;
		cyc(4);
		`CHK({bin, peak, cft, knee, slope, clamp}, {4'h2, 3'h0, 4'h1, 4'h4, 2'h3, 3'h1})
	endtask
	// ramp compare: half, rescaled peak, offset edge, clamp
	task automatic t_dc;
		int c;
		@(posedge clk);
		lvl <= 12'h3D9;
		cyc(3);
		duty(c);
		`CHK(c, 50)
		host.wr(LDC_A_PEAK, 8'h07);
		cyc(3);
		duty(c);
		`CHK(c, 27)
		@(posedge clk);
		lvl <= 12'h0D2;
		cyc(3);
		duty(c);
		`CHK(c, 0)
		@(posedge clk);
		lvl <= 12'hFFF;
		cyc(3);
		duty(c);
		`CHK(c, 100)
	endtask
	// enable, foldback pin and pin routing
	task automatic t_pins;
		@(posedge clk);
		{en, fb_pin, prog} <= 3'h1;
		cyc(4);
		`CHK({led_en, aux_en, gate, fb_en}, 4'h0)
		`CHK({bus_sel, th_sel}, 2'h2)
		`CHK({bus_ded, th_ded}, 2'h2)
		@(posedge clk);
		{en, fb_pin, prog} <= 3'h6;
		cyc(4);
		`CHK({led_en, aux_en, fb_en, bus_sel, th_sel}, 5'h1D)
		`CHK({bus_ded, th_ded}, 2'h2)
	endtask
	// pulse detect, follow, and timeout back to ramp mode
	task automatic t_pwm;
		int c;
		pulses(6, 2, 2);
		cyc(3);
		`CHK(pwm, 1'h0)
		pulses(3, 20, 20);
		cyc(4);
		`CHK(pwm, 1'h1)
		@(posedge clk);
		brightness_control_input <= 1'h0;
		cyc(3);
		duty(c);
		`CHK(c, 0)
		cyc(300);
		`CHK(pwm, 1'h0)
		duty(c);
		`CHK(c, 100)
		pulses(3, 20, 20);
		cyc(4);
		`CHK(pwm, 1'h1)
		cyc(400);
		`CHK(pwm, 1'h0)
	endtask
	// button latch, bounce, foldback precedence
	task automatic t_btn;
		int c;
		@(posedge clk);
		lvl <= 12'h000;
		press(DB - 5);
		`CHK(full, 1'h0)
		press(DB + 10);
		`CHK(full, 1'h1)
		duty(c);
		`CHK(c, 100)
		@(posedge clk);
		fb_act <= 1'h1;
		cyc(4);
		duty(c);
		`CHK(c, 0)
		@(posedge clk);
		fb_pin <= 1'h0;
		cyc(4);
		duty(c);
		`CHK(c, 100)
		@(posedge clk);
		fb_pin <= 1'h1;
		fb_act <= 1'h0;
		press(DB + 10);
		`CHK(full, 1'h0)
		duty(c);
		`CHK(c, 0)
	endtask
	// supply loss in mid-run clears settings, stored copy returns
	task automatic t_reset;
		@(posedge clk);
		rst <= 1'h1;
		cyc(3);
		`CHK({bin, peak, cft, knee, slope, clamp, valid, gate}, 22'h0)
		@(posedge clk);
		rst <= 1'h0;
		cyc(4);
		`CHK({bin, peak, cft, knee, slope, clamp, valid}, {nb, np, nc, nk, ns, nl, 1'h1})
	endtask
	// verdict and end of run
	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// main sequence
	initial begin
		{rst, en, fb_pin, brightness_control_input, btn, prog, fb_act, fb_gate} = 8'hE0;
		lvl = 12'h000;
		{nb, np, nc, nk, ns, nl} = {4'hA, 3'h7, 4'h5, 4'h3, 2'h2, 3'h6};
		cyc(10);
		t_boot;
		t_regs;
		t_xfer;
		t_dc;
		t_pins;
		t_pwm;
		t_btn;
		t_reset;
		end_sim;
	end
	// watchdog against a hang
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		end_sim;
	end
endmodule
